//--- logic/ims_defs.svh
`ifndef IMS_DEFS_SVH
`define IMS_DEFS_SVH

`define IMS_BYTE_W          8
`define IMS_BYTE_RESET      8'h00
`define IMS_LAST_BIT        4'h8
`define IMS_TICK_W          6
`define IMS_QUARTER_NS      2500
`define IMS_LINK_PERIOD_NS  80
`define IMS_QUARTER_TICKS   ((`IMS_QUARTER_NS + `IMS_LINK_PERIOD_NS - 1) / `IMS_LINK_PERIOD_NS)

`endif

//--- logic/ims_pkg.sv
package ims_pkg;

	typedef enum logic [1:0] {
		IMS_CMD_WRITE       = 2'b00,
		IMS_CMD_WRITE_START = 2'b01,
		IMS_CMD_READ        = 2'b10,
		IMS_CMD_STOP        = 2'b11
	} ims_cmd_type;

	typedef enum logic [1:0] {
		IMS_SEQ_IDLE = 2'b00,
		IMS_SEQ_BUSY = 2'b01,
		IMS_SEQ_NEXT = 2'b10,
		IMS_SEQ_HALT = 2'b11
	} ims_seq_state_type;

	typedef enum logic [1:0] {
		IMS_ENG_IDLE  = 2'b00,
		IMS_ENG_START = 2'b01,
		IMS_ENG_BITS  = 2'b10,
		IMS_ENG_STOP  = 2'b11
	} ims_eng_state_type;

endpackage

//--- logic/ims_sync.sv
module ims_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta;

	// Two stages; only the second is ever read outside
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule

//--- logic/ims_bit_engine.sv
`include "ims_defs.svh"

module ims_bit_engine #(
	parameter int QUARTER_TICKS = `IMS_QUARTER_TICKS
) (
	input  wire logic                    link_clk,
	input  wire logic                    reset,
	input  wire logic                    req_tgl,
	input  wire ims_pkg::ims_cmd_type    cmd,
	input  wire logic [`IMS_BYTE_W-1:0]  cmd_data,
	input  wire logic                    nak_bit,
	input  wire logic                    sda_in,
	output logic                         done_tgl,
	output logic                         first_tgl,
	output logic                         ack_ok,
	output logic      [`IMS_BYTE_W-1:0]  rx_byte,
	output logic                         sda_oe_n,
	output logic                         scl_oe_n
);

	localparam logic [`IMS_TICK_W-1:0] TICK_LAST = `IMS_TICK_W'(QUARTER_TICKS - 1);

	ims_pkg::ims_eng_state_type state, next_state;
	logic [`IMS_TICK_W-1:0]     tick, next_tick;
	logic [1:0]                 phase, next_phase;
	logic [3:0]                 bitn, next_bitn;
	logic [8:0]                 shreg, next_shreg;
	logic [8:0]                 inreg, next_inreg;
	logic                       is_read, next_is_read;
	logic                       req_seen, next_req_seen;
	logic                       next_done_tgl, next_first_tgl, next_ack_ok;
	logic [`IMS_BYTE_W-1:0]     next_rx_byte;
	logic                       next_sda_oe_n, next_scl_oe_n;
	logic                       adv, req_s, sda_s;

	ims_sync #(.WIDTH(2)) u_sync (
		.clk   (link_clk),
		.reset (reset),
		.d     ({req_tgl, sda_in}),
		.q     ({req_s, sda_s})
	);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state     = state;
		next_tick      = tick;
		next_phase     = phase;
		next_bitn      = bitn;
		next_shreg     = shreg;
		next_inreg     = inreg;
		next_is_read   = is_read;
		next_req_seen  = req_seen;
		next_done_tgl  = done_tgl;
		next_first_tgl = first_tgl;
		next_ack_ok    = ack_ok;
		next_rx_byte   = rx_byte;
		next_sda_oe_n  = sda_oe_n;
		next_scl_oe_n  = scl_oe_n;
		adv            = (tick == TICK_LAST);
		if (state == ims_pkg::IMS_ENG_IDLE) begin
			next_tick = '0;
		end else begin
			next_tick = adv ? '0 : tick + 1'b1;
			if (adv) begin
				next_phase = phase + 2'b01;
			end
		end
		case (state)
			ims_pkg::IMS_ENG_IDLE: begin
				next_phase = 2'b00;
				if (req_s != req_seen) begin
					next_req_seen = req_s;
					next_bitn     = 4'h0;
					next_is_read  = (cmd == ims_pkg::IMS_CMD_READ);
					next_shreg    = (cmd == ims_pkg::IMS_CMD_READ) ? {8'hFF, nak_bit} : {cmd_data, 1'b1};
					case (cmd)
						ims_pkg::IMS_CMD_WRITE_START: next_state = ims_pkg::IMS_ENG_START;
						ims_pkg::IMS_CMD_STOP:        next_state = ims_pkg::IMS_ENG_STOP;
						default:                      next_state = ims_pkg::IMS_ENG_BITS;
					endcase
				end
			end
			ims_pkg::IMS_ENG_START: begin
				if (adv) begin
					case (phase)
						2'b00:   next_sda_oe_n = 1'b1;
						2'b01:   next_scl_oe_n = 1'b1;
						2'b10:   next_sda_oe_n = 1'b0;
						default: begin
							next_scl_oe_n = 1'b0;
							next_state    = ims_pkg::IMS_ENG_BITS;
						end
					endcase
				end
			end
			ims_pkg::IMS_ENG_BITS: begin
				if (adv) begin
					case (phase)
						2'b00:   next_sda_oe_n = shreg[8];
						2'b01:   next_scl_oe_n = 1'b1;
						2'b10:   next_inreg = {inreg[7:0], sda_s};
						default: begin
							next_scl_oe_n = 1'b0;
							next_shreg    = {shreg[7:0], 1'b1};
							next_bitn     = bitn + 4'h1;
							if (bitn == 4'h0 && !is_read) begin
								next_first_tgl = ~first_tgl;
							end
							if (bitn == `IMS_LAST_BIT) begin
								next_ack_ok   = ~inreg[0];
								next_rx_byte  = inreg[8:1];
								next_done_tgl = ~done_tgl;
								next_state    = ims_pkg::IMS_ENG_IDLE;
							end
						end
					endcase
				end
			end
			default: begin
				if (adv) begin
					case (phase)
						2'b00:   next_sda_oe_n = 1'b0;
						2'b01:   next_scl_oe_n = 1'b1;
						2'b10:   next_sda_oe_n = 1'b1;
						default: begin
							next_done_tgl = ~done_tgl;
							next_state    = ims_pkg::IMS_ENG_IDLE;
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge link_clk or posedge reset) begin
		if (reset) begin
			state     <= ims_pkg::IMS_ENG_IDLE;
			tick      <= '0;
			phase     <= 2'b00;
			bitn      <= 4'h0;
			shreg     <= 9'h1FF;
			inreg     <= 9'h000;
			is_read   <= 1'b0;
			req_seen  <= 1'b0;
			done_tgl  <= 1'b0;
			first_tgl <= 1'b0;
			ack_ok    <= 1'b0;
			rx_byte   <= `IMS_BYTE_RESET;
			sda_oe_n  <= 1'b1;
			scl_oe_n  <= 1'b1;
		end else begin
			state     <= next_state;
			tick      <= next_tick;
			phase     <= next_phase;
			bitn      <= next_bitn;
			shreg     <= next_shreg;
			inreg     <= next_inreg;
			is_read   <= next_is_read;
			req_seen  <= next_req_seen;
			done_tgl  <= next_done_tgl;
			first_tgl <= next_first_tgl;
			ack_ok    <= next_ack_ok;
			rx_byte   <= next_rx_byte;
			sda_oe_n  <= next_sda_oe_n;
			scl_oe_n  <= next_scl_oe_n;
		end
	end

endmodule

//--- logic/ims_master_sequencer.sv
`include "ims_defs.svh"

module ims_master_sequencer #(
	parameter int QUARTER_TICKS = `IMS_QUARTER_TICKS
) (
	input  wire logic                   clk,
	input  wire logic                   reset,
	input  wire logic                   link_clk,
	input  wire logic                   block_enable,
	input  wire logic                   tx_irq_enable,
	input  wire logic                   nak_ctrl,
	input  wire logic                   start_set,
	input  wire logic                   stop_set,
	input  wire logic                   data_wr,
	input  wire logic [`IMS_BYTE_W-1:0] data_wr_value,
	input  wire logic                   data_rd,
	input  wire logic                   sda_in,
	output logic      [`IMS_BYTE_W-1:0] rx_data,
	output logic                        rx_full,
	output logic                        tx_holding_empty,
	output logic                        ack_status,
	output logic                        ack_valid_flag,
	output logic                        no_ack_irq_flag,
	output logic                        start_pending,
	output logic                        stop_pending,
	output logic                        busy,
	output logic                        irq,
	output logic                        sda_out,
	output logic                        sda_oe_n,
	output logic                        scl_out,
	output logic                        scl_oe_n
);

	ims_pkg::ims_seq_state_type state, next_state;
	ims_pkg::ims_cmd_type       cmd, next_cmd;
	logic [`IMS_BYTE_W-1:0]     cmd_data, next_cmd_data;
	logic                       cmd_nak, next_cmd_nak;
	logic                       req_tgl, next_req_tgl;
	logic [`IMS_BYTE_W-1:0]     tx_hold, next_tx_hold;
	logic                       hold_valid, next_hold_valid;
	logic                       awaiting_first, next_awaiting_first;
	logic                       in_read, next_in_read;
	logic                       done_seen, next_done_seen;
	logic                       first_seen, next_first_seen;
	logic [`IMS_BYTE_W-1:0]     next_rx_data;
	logic                       next_rx_full, next_tx_holding_empty;
	logic                       next_ack_status, next_ack_valid_flag, next_no_ack_irq_flag;
	logic                       next_start_pending, next_stop_pending, next_busy, next_irq;
	logic                       issue;
	ims_pkg::ims_cmd_type       issue_cmd;
	logic                       done_s, first_s, eng_done_tgl, eng_first_tgl, eng_ack_ok;
	logic [`IMS_BYTE_W-1:0]     eng_rx_byte;
	logic                       done_evt, first_evt;

	////////////////////////////////////////////////////////////////////////////////
	// Link side; command words stay still until the done toggle returns
	ims_bit_engine #(.QUARTER_TICKS(QUARTER_TICKS)) u_engine (
		.link_clk  (link_clk),
		.reset     (reset),
		.req_tgl   (req_tgl),
		.cmd       (cmd),
		.cmd_data  (cmd_data),
		.nak_bit   (cmd_nak),
		.sda_in    (sda_in),
		.done_tgl  (eng_done_tgl),
		.first_tgl (eng_first_tgl),
		.ack_ok    (eng_ack_ok),
		.rx_byte   (eng_rx_byte),
		.sda_oe_n  (sda_oe_n),
		.scl_oe_n  (scl_oe_n)
	);

	ims_sync #(.WIDTH(2)) u_evt_sync (
		.clk   (clk),
		.reset (reset),
		.d     ({eng_done_tgl, eng_first_tgl}),
		.q     ({done_s, first_s})
	);

	assign done_evt  = (done_s != done_seen);
	assign first_evt = (first_s != first_seen);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state           = state;
		next_cmd             = cmd;
		next_cmd_data        = cmd_data;
		next_cmd_nak         = cmd_nak;
		next_req_tgl         = req_tgl;
		next_tx_hold         = tx_hold;
		next_hold_valid      = hold_valid;
		next_awaiting_first  = awaiting_first;
		next_in_read         = in_read;
		next_done_seen       = done_s;
		next_first_seen      = first_s;
		next_rx_data         = rx_data;
		next_rx_full         = rx_full;
		next_ack_status      = ack_status;
		next_ack_valid_flag  = ack_valid_flag;
		next_no_ack_irq_flag = no_ack_irq_flag;
		next_start_pending   = start_pending;
		next_stop_pending    = stop_pending;
		issue                = 1'b0;
		issue_cmd            = ims_pkg::IMS_CMD_WRITE;
		if (first_evt) begin
			next_awaiting_first = 1'b0;
		end
		if (data_rd) begin
			next_rx_full = 1'b0;
		end
		case (state)
			ims_pkg::IMS_SEQ_IDLE: begin
				// Nothing on the bus to stop
				if (stop_pending && !start_pending) begin
					next_stop_pending = 1'b0;
				end
				if (block_enable && start_pending && hold_valid) begin
					issue     = 1'b1;
					issue_cmd = ims_pkg::IMS_CMD_WRITE_START;
				end
			end
			ims_pkg::IMS_SEQ_BUSY: begin
				if (done_evt) begin
					case (cmd)
						ims_pkg::IMS_CMD_STOP: begin
							next_stop_pending    = 1'b0;
							next_no_ack_irq_flag = 1'b0;
							next_in_read         = 1'b0;
							next_state           = ims_pkg::IMS_SEQ_IDLE;
						end
						ims_pkg::IMS_CMD_READ: begin
							next_rx_data = eng_rx_byte;
							next_rx_full = 1'b1;
							if (cmd_nak) begin
								next_no_ack_irq_flag = 1'b1;
								next_state           = ims_pkg::IMS_SEQ_HALT;
							end else begin
								next_state = ims_pkg::IMS_SEQ_NEXT;
							end
						end
						default: begin
							next_ack_valid_flag = 1'b1;
							next_ack_status     = eng_ack_ok;
							if (!eng_ack_ok) begin
								next_no_ack_irq_flag = 1'b1;
								next_hold_valid      = 1'b0;
								next_state           = ims_pkg::IMS_SEQ_HALT;
							end else begin
								if (cmd == ims_pkg::IMS_CMD_WRITE_START) begin
									next_in_read = cmd_data[0];
								end
								next_state = ims_pkg::IMS_SEQ_NEXT;
							end
						end
					endcase
				end
			end
			ims_pkg::IMS_SEQ_NEXT: begin
				if (stop_pending) begin
					issue     = 1'b1;
					issue_cmd = ims_pkg::IMS_CMD_STOP;
				end else if (start_pending && hold_valid) begin
					issue     = 1'b1;
					issue_cmd = ims_pkg::IMS_CMD_WRITE_START;
				end else if (in_read && !rx_full) begin
					issue     = 1'b1;
					issue_cmd = ims_pkg::IMS_CMD_READ;
				end else if (!in_read && hold_valid) begin
					issue     = 1'b1;
					issue_cmd = ims_pkg::IMS_CMD_WRITE;
				end
			end
			default: begin
				if (stop_pending) begin
					issue     = 1'b1;
					issue_cmd = ims_pkg::IMS_CMD_STOP;
				end else if (start_pending && hold_valid) begin
					issue                = 1'b1;
					issue_cmd            = ims_pkg::IMS_CMD_WRITE_START;
					next_no_ack_irq_flag = 1'b0;
				end
			end
		endcase
		if (issue) begin
			next_req_tgl = ~req_tgl;
			next_cmd     = issue_cmd;
			next_state   = ims_pkg::IMS_SEQ_BUSY;
			case (issue_cmd)
				ims_pkg::IMS_CMD_STOP: begin
				end
				ims_pkg::IMS_CMD_READ: begin
					next_cmd_nak = nak_ctrl;
				end
				default: begin
					next_cmd_data       = tx_hold;
					next_hold_valid     = 1'b0;
					next_awaiting_first = 1'b1;
					if (issue_cmd == ims_pkg::IMS_CMD_WRITE_START) begin
						next_start_pending  = 1'b0;
						next_ack_valid_flag = 1'b0;
						next_in_read        = 1'b0;
					end
				end
			endcase
		end
		// A write after consumption is fresh data
		if (data_wr) begin
			next_tx_hold    = data_wr_value;
			next_hold_valid = 1'b1;
		end
		// Requests set after clears so they are never lost
		if (start_set) begin
			next_start_pending = 1'b1;
		end
		if (stop_set) begin
			next_stop_pending = 1'b1;
		end
		next_tx_holding_empty = !next_hold_valid && !next_awaiting_first;
		next_irq  = block_enable && ((tx_irq_enable && next_tx_holding_empty) || next_rx_full || next_no_ack_irq_flag);
		next_busy = (next_state != ims_pkg::IMS_SEQ_IDLE);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state            <= ims_pkg::IMS_SEQ_IDLE;
			cmd              <= ims_pkg::IMS_CMD_WRITE;
			cmd_data         <= `IMS_BYTE_RESET;
			cmd_nak          <= 1'b0;
			req_tgl          <= 1'b0;
			tx_hold          <= `IMS_BYTE_RESET;
			hold_valid       <= 1'b0;
			awaiting_first   <= 1'b0;
			in_read          <= 1'b0;
			done_seen        <= 1'b0;
			first_seen       <= 1'b0;
			rx_data          <= `IMS_BYTE_RESET;
			rx_full          <= 1'b0;
			tx_holding_empty <= 1'b1;
			ack_status       <= 1'b0;
			ack_valid_flag   <= 1'b0;
			no_ack_irq_flag  <= 1'b0;
			start_pending    <= 1'b0;
			stop_pending     <= 1'b0;
			busy             <= 1'b0;
			irq              <= 1'b0;
			sda_out          <= 1'b0;
			scl_out          <= 1'b0;
		end else begin
			state            <= next_state;
			cmd              <= next_cmd;
			cmd_data         <= next_cmd_data;
			cmd_nak          <= next_cmd_nak;
			req_tgl          <= next_req_tgl;
			tx_hold          <= next_tx_hold;
			hold_valid       <= next_hold_valid;
			awaiting_first   <= next_awaiting_first;
			in_read          <= next_in_read;
			done_seen        <= next_done_seen;
			first_seen       <= next_first_seen;
			rx_data          <= next_rx_data;
			rx_full          <= next_rx_full;
			tx_holding_empty <= next_tx_holding_empty;
			ack_status       <= next_ack_status;
			ack_valid_flag   <= next_ack_valid_flag;
			no_ack_irq_flag  <= next_no_ack_irq_flag;
			start_pending    <= next_start_pending;
			stop_pending     <= next_stop_pending;
			busy             <= next_busy;
			irq              <= next_irq;
			sda_out          <= 1'b0;
			scl_out          <= 1'b0;
		end
	end

endmodule

//--- verification/ims_master_sequencer_chk.sv
module ims_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic block_enable,
	input wire logic tx_irq_enable,
	input wire logic data_wr,
	input wire logic data_rd,
	input wire logic rx_full,
	input wire logic tx_holding_empty,
	input wire logic ack_status,
	input wire logic ack_valid_flag,
	input wire logic no_ack_irq_flag,
	input wire logic start_pending,
	input wire logic stop_pending,
	input wire logic busy,
	input wire logic irq,
	input wire logic sda_out,
	input wire logic scl_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Ready to launch
	sequence s_launch_ready;
		start_pending && !tx_holding_empty && block_enable && !busy;
	endsequence
	// START takes many cycles before the first bit leaves
	sequence s_first_bit;
		!tx_holding_empty [*8] ##[1:300] tx_holding_empty;
	endsequence
	////////////////////////////////////////////////////////////
	// irq on empty
	AST_IRQ_TX: assert property ((block_enable && tx_irq_enable && tx_holding_empty) [*2] |-> irq)
		else $error("irq missing while data register empty");
	AST_IRQ_OFF: assert property (!block_enable [*2] |-> !irq)
		else $error("irq while block disabled");
	AST_WR_FULL: assert property (data_wr |=> !tx_holding_empty)
		else $error("data register still empty after write");
	AST_NACK: assert property ($rose(no_ack_irq_flag) && !rx_full |-> ack_valid_flag && !ack_status && tx_holding_empty)
		else $error("refusal flags or flush wrong");
	AST_STOP_END: assert property ($fell(stop_pending) |-> !no_ack_irq_flag ##[0:1] !busy)
		else $error("stop left flag or busy");
	AST_HOLD: assert property (!busy && tx_holding_empty |=> !busy)
		else $error("launch with empty data register");
	AST_LAUNCH: assert property (s_launch_ready |-> ##[1:2] busy)
		else $error("start not launched");
	AST_FIRST_BIT: assert property ($rose(busy) |-> s_first_bit)
		else $error("empty flag timing wrong after launch");
	AST_RX_CLR: assert property (data_rd && rx_full |=> !rx_full)
		else $error("receive flag not cleared");
	AST_OPEN: assert property (!sda_out && !scl_out)
		else $error("wire driven high");
endmodule

bind ims_master_sequencer ims_chk u_chk (.clk, .reset, .block_enable, .tx_irq_enable, .data_wr, .data_rd,
	.rx_full, .tx_holding_empty, .ack_status, .ack_valid_flag, .no_ack_irq_flag, .start_pending,
	.stop_pending, .busy, .irq, .sda_out, .scl_out);

//--- verification/ims_slave_model.sv
module ims_slave_model (
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic [7:0] refuse_at,
	input  wire logic [7:0] rd_base,
	output logic            pull
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh, idx, stops, tx;
	logic [7:0] seen [0:7];
	logic       acks [0:7];
	logic [3:0] cnt;
	logic       rd, go_rd, mack;

	initial begin
		stops = 8'h00;
		pull = 1'b0;
	end
	////////////////////////////////////////////////////////////
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			cnt = 4'h0;
			idx = 8'h00;
			rd = 1'b0;
			go_rd = 1'b0;
		end
	end
	// The wires rise from unknown at power-up; that edge is no STOP
	always @(posedge sda) begin
		if (scl === 1'b1 && $time > 0) begin
			stops = stops + 8'h01;
			rd = 1'b0;
		end
	end
	always @(posedge scl) begin
		cnt = cnt + 4'h1;
		if (cnt == 4'h9)
			mack = !sda;
		else
			sh = {sh[6:0], sda};
	end
	// Data changes only while SCL is low, so no false START or STOP
	always @(negedge scl) begin
		if (cnt == 4'h8) begin
			seen[idx[2:0]] = sh;
			pull = !rd && idx != refuse_at;
			go_rd = idx == 8'h00 && sh[0] && pull;
		end else if (cnt == 4'h9) begin
			acks[idx[2:0]] = mack;
			pull = 1'b0;
			rd = go_rd || (rd && mack);
			go_rd = 1'b0;
			cnt = 4'h0;
			idx = idx + 8'h01;
		end
		tx = rd_base + idx;
		if (rd && cnt < 4'h8)
			pull = !tx[3'h7 - cnt[2:0]];
	end
endmodule

//--- verification/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk, reset, link_clk, block_enable, tx_irq_enable, nak_ctrl, start_set, stop_set;
	logic       data_wr, data_rd, rx_full, tx_holding_empty, ack_status, ack_valid_flag, no_ack_irq_flag;
	logic       start_pending, stop_pending, busy, irq, sda_out, sda_oe_n, scl_out, scl_oe_n;
	logic       sda, scl, pull;
	logic [7:0] data_wr_value, rx_data, refuse_at, rd_base, ns;
	int         failures, comparisons;

	// Both wires have pull-ups; released means high
	assign sda = (sda_oe_n ? 1'b1 : sda_out) & !pull;
	assign scl = scl_oe_n ? 1'b1 : scl_out;

	ims_master_sequencer #(.QUARTER_TICKS(2)) u_dut (.clk, .reset, .link_clk, .block_enable, .tx_irq_enable,
		.nak_ctrl, .start_set, .stop_set, .data_wr, .data_wr_value, .data_rd, .sda_in(sda), .rx_data, .rx_full,
		.tx_holding_empty, .ack_status, .ack_valid_flag, .no_ack_irq_flag, .start_pending, .stop_pending,
		.busy, .irq, .sda_out, .sda_oe_n, .scl_out, .scl_oe_n);
	ims_slave_model u_slv (.scl, .sda, .refuse_at, .rd_base, .pull);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#13;
		forever #40 link_clk = ~link_clk;
	end
	////////////////////////////////////////////////////////////
	task give_verdict();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, got, exp);
		end
	endtask
	// 0 write data, 1 start, 2 stop, 3 read data
	task pulse(input int s, input logic [7:0] v);
		@(negedge clk);
		data_wr_value = v;
		case (s)
			0: data_wr = 1'b1;
			1: start_set = 1'b1;
			2: stop_set = 1'b1;
			default: data_rd = 1'b1;
		endcase
		@(negedge clk);
		{data_wr, start_set, stop_set, data_rd} = 4'h0;
	endtask
	function logic cond(input int c);
		case (c)
			0: return tx_holding_empty;
			1: return !busy;
			2: return no_ack_irq_flag;
			default: return rx_full;
		endcase
	endfunction
	task await(input int c);
		int n;
		n = 0;
		while (cond(c) !== 1'b1 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		if (n == 20000) begin
			failures++;
			$display("[ERR] %0t wait ran out", $time);
			give_verdict();
		end
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		reset = 1'b1;
		{block_enable, tx_irq_enable, nak_ctrl, start_set, stop_set, data_wr, data_rd} = 7'h00;
		{data_wr_value, refuse_at, rd_base, ns} = 32'h0000_0000;
		failures = 0;
		comparisons = 0;
		repeat (20) @(negedge clk);
		reset = 1'b0;
		block_enable = 1'b1;
		repeat (2) @(negedge clk);
		chk(tx_holding_empty, 8'h01);
		chk(irq, 8'h00);
		tx_irq_enable = 1'b1;
		repeat (2) @(negedge clk);
		chk(irq, 8'h01);
		// Ten-bit write: clean, first address refused, data byte refused
		for (int k = 0; k < 3; k++) begin
			refuse_at = k == 0 ? 8'hff : (k == 1 ? 8'h00 : 8'h02);
			tx_irq_enable = 1'b1;
			pulse(0, 8'hf6);
			pulse(1, 8'h00);
			await(0);
			chk(start_pending, 8'h00);
			pulse(0, 8'h5a);
			if (k != 1) begin
				await(0);
				pulse(0, 8'h3c);
				await(0);
				if (k == 2)
					pulse(0, 8'h77);
			end
			if (k != 0) begin
				await(2);
				chk(ack_valid_flag, 8'h01);
				chk(ack_status, 8'h00);
				chk(tx_holding_empty, 8'h01);
				chk(busy, 8'h01);
				tx_irq_enable = 1'b0;
			end else
				chk(ack_status, 8'h01);
			pulse(2, 8'h00);
			await(1);
			ns = ns + 8'h01;
			chk(u_slv.stops, ns);
			chk(no_ack_irq_flag, 8'h00);
			chk(stop_pending, 8'h00);
			chk(u_slv.seen[0], 8'hf6);
			chk(u_slv.idx, k == 1 ? 8'h01 : 8'h03);
			if (k != 1)
				chk(u_slv.seen[1], 8'h5a);
			if (k == 0)
				chk(u_slv.seen[2], 8'h3c);
		end
		// Seven-bit read of one and of two bytes
		for (int n = 1; n <= 2; n++) begin
			rd_base = 8'hc3 + 8'(n);
			nak_ctrl = n == 1;
			if (n == 1) begin
				// Refused attempt leaves the sequencer halted; a new start must still launch
				refuse_at = 8'h00;
				pulse(0, 8'hf0);
				pulse(1, 8'h00);
				await(2);
				chk(ack_status, 8'h00);
				refuse_at = 8'hff;
			end
			pulse(0, 8'ha1);
			pulse(1, 8'h00);
			for (int b = 0; b < n; b++) begin
				await(3);
				chk(rx_data, rd_base + 8'(b + 1));
				if (b == n - 1)
					await(2);
				else
					nak_ctrl = 1'b1;
				pulse(3, 8'h00);
			end
			chk(u_slv.acks[n], 8'h00);
			if (n == 2)
				chk(u_slv.acks[1], 8'h01);
			nak_ctrl = 1'b0;
			pulse(2, 8'h00);
			await(1);
			ns = ns + 8'h01;
			chk(u_slv.stops, ns);
			chk(no_ack_irq_flag, 8'h00);
			chk(u_slv.seen[0], 8'ha1);
		end
		// Stop with nothing on the bus is dropped without a STOP
		pulse(2, 8'h00);
		repeat (2) @(negedge clk);
		chk(stop_pending, 8'h00);
		chk(busy, 8'h00);
		chk(u_slv.stops, ns);
		give_verdict();
	end
endmodule
